// ===== inc/tim_ext_pkg.sv
package tim_ext_pkg;
  localparam int CNT_W   = 16;
  localparam int NCH     = 4;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  // Register offsets
  localparam logic [ADDR_W-1:0] CONTROL_ONE_OFS    = 8'h00;
  localparam logic [ADDR_W-1:0] SLAVE_CONTROL_OFS  = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_DMA_ENABLE_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] FLAG_OFS           = 8'h10;
  localparam logic [ADDR_W-1:0] EVENT_TRIGGER_OFS  = 8'h14;
  localparam logic [ADDR_W-1:0] CH_MODE_OFS        = 8'h18;
  localparam logic [ADDR_W-1:0] CH_ENABLE_POL_OFS  = 8'h20;
  localparam logic [ADDR_W-1:0] COUNT_OFS          = 8'h24;
  localparam logic [ADDR_W-1:0] WRAP_OFS           = 8'h2C;
  localparam logic [ADDR_W-1:0] COMPARE0_OFS       = 8'h34;
  // Control one fields
  localparam int RUN_POS = 0;
  localparam int SHOT_POS = 3;
  localparam int DIR_POS = 4;
  localparam int WPRE_POS = 7;
  // Slave control fields
  localparam int SMODE_POS = 0;
  localparam int TSRC_POS  = 4;
  localparam int PRELOAD_CTRL_POS = 8;
  // Flag / enable fields
  localparam int PHASE_POS = 5;
  localparam int DMA_PHASE_POS = 13;
  // Event trigger fields
  localparam int FUPD_POS = 0;
  localparam int PHASE_EV_POS = 5;
  // Channel mode: per channel byte: [1:0] map, [2] fast, [3] cmp preload, [6:4] mode
  localparam int CH_STRIDE = 8;
  // Channel enable/polarity: per channel nibble: [0] en, [1] pol, [2] comp en
  localparam int EP_STRIDE = 4;
  // Codes
  localparam logic [2:0] SM_ENC_SECOND = 3'b001;
  localparam logic [2:0] SM_ENC_FIRST  = 3'b010;
  localparam logic [2:0] SM_ENC_BOTH   = 3'b011;
  localparam logic [2:0] SM_TRIGGER    = 3'b110;
  localparam logic [2:0] TS_SECOND     = 3'b110;
  localparam logic [2:0] TS_FIRST      = 3'b101;
  localparam logic [1:0] MAP_OWN_PIN   = 2'b01;
  localparam logic [2:0] OM_PWM1       = 3'b110;
  localparam logic [2:0] OM_PWM2       = 3'b111;
  // Reset values
  localparam logic [CNT_W-1:0] WRAP_RST = 16'hFFFF;

  typedef struct packed {
    logic [2:0] output_mode_field;
    logic       main_output_enable;
    logic       complementary_output_enable;
  } chan_cfg_t;

  typedef struct packed {
    logic step;
    logic down;
  } enc_step_t;
endpackage

// ===== design/input_conditioner.sv
`timescale 1ns/1ps
module input_conditioner
  import tim_ext_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pin,
  input  wire logic invert,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_q;
  logic sync_q;
  logic level_q;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
    end
  end

  // Polarity applied after sync, no filter so level tracks pin
  always_ff @(posedge sys_clk) begin
    if (rst) level_q <= 1'b0;
    else     level_q <= sync_q ^ invert;
  end

  assign level = level_q;
  assign rise  = (sync_q ^ invert) & ~level_q;
  assign fall  = ~(sync_q ^ invert) & level_q;
endmodule // input_conditioner

// ===== design/quad_decoder.sv
`timescale 1ns/1ps
module quad_decoder
  import tim_ext_pkg::*;
(
  input  wire logic       first_lvl,
  input  wire logic       first_rise,
  input  wire logic       first_fall,
  input  wire logic       second_lvl,
  input  wire logic       second_rise,
  input  wire logic       second_fall,
  input  wire logic [2:0] mode,
  output enc_step_t       result,
  output logic            any_edge
);
  logic use_first;
  logic use_second;
  logic first_down;
  logic second_down;

  // Counting selection per encoder mode code
  assign use_first  = (mode == SM_ENC_FIRST) || (mode == SM_ENC_BOTH);
  assign use_second = (mode == SM_ENC_SECOND) || (mode == SM_ENC_BOTH);

  // Direction table, opposite level decides
  assign first_down  = first_rise ? second_lvl : ~second_lvl;
  assign second_down = second_rise ? ~first_lvl : first_lvl;

  // Edges assumed separated; first input wins if both arrive together
  assign any_edge = first_rise | first_fall | second_rise | second_fall;

  always_comb begin
    result = '0;
    if (first_rise | first_fall) begin
      result.down = first_down;
      result.step = use_first;
    end else if (second_rise | second_fall) begin
      result.down = second_down;
      result.step = use_second;
    end
  end
endmodule // quad_decoder

// ===== design/tim_ext_core.sv
`timescale 1ns/1ps
// Operation
// - Preloaded channel config copied together on event
// - Event from software bit or trigger rise
// - Event sets flag, irq and dma requests
// - Single-shot stops counter at update event, but not on forced update or in encoder mode
// - Trigger edge sets run bit in trigger mode
// - Delay is compare, length wrap minus compare plus one
// - Mode 111 rises at match, falls at wrap
// - Fast enable forces match level on trigger
// - Codes select second input, trigger mode, mapping
// - Encoder codes select which inputs count
// - Polarity bit inverts each encoder input
// - Encoder steps per valid edge while running
// - Direction updated on every input edge
// - Encoder counts between zero and wrap limit
// - Compare logic keeps working in encoder mode
// - First input edge direction table
// - Second input edge direction table
module tim_ext_core
  import tim_ext_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic              first_timer_pin,
  input  wire logic              second_timer_pin,
  output logic      [NCH-1:0]    reference_output,
  output logic      [NCH-1:0]    main_output,
  output logic      [NCH-1:0]    complementary_output,
  output logic                   phase_switch_irq,
  output logic                   phase_switch_dma_req,
  output logic      [CNT_W-1:0]  count_value
);
  // Software registers
  logic             counter_run_bit_q;
  logic             single_shot_bit_q;
  logic             dir_q;
  logic             wrap_preload_enable_q;
  logic [2:0]       slave_behaviour_sel_q;
  logic [2:0]       trigger_source_sel_q;
  logic             cfg_preload_q;
  logic             phase_switch_irq_enable_q;
  logic             phase_switch_dma_enable_q;
  logic             phase_switch_flag_q;
  logic [1:0]       input_map_select_q [NCH];
  logic [NCH-1:0]   fast_output_enable_q;
  logic [NCH-1:0]   compare_preload_enable_q;
  logic [NCH-1:0]   out_polarity_q;
  chan_cfg_t        cfg_pre_q [NCH];
  chan_cfg_t        cfg_act_q [NCH];
  logic [CNT_W-1:0] wrap_pre_q;
  logic [CNT_W-1:0] wrap_act_q;
  logic [CNT_W-1:0] cmp_pre_q [NCH];
  logic [CNT_W-1:0] cmp_act_q [NCH];
  logic [CNT_W-1:0] cnt_q;
  logic [NCH-1:0]   ref_q;
  logic [DATA_W-1:0] rdata_q;
  logic             trig_lvl_q;

  // Conditioned inputs
  logic first_lvl, first_rise, first_fall;
  logic second_lvl, second_rise, second_fall;
  enc_step_t enc;
  logic enc_edge;

  input_conditioner u_first (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (first_timer_pin),
    .invert  (out_polarity_q[0]),
    .level   (first_lvl),
    .rise    (first_rise),
    .fall    (first_fall)
  );

  input_conditioner u_second (
    .sys_clk (sys_clk),
    .rst     (rst),
    .pin     (second_timer_pin),
    .invert  (out_polarity_q[1]),
    .level   (second_lvl),
    .rise    (second_rise),
    .fall    (second_fall)
  );

  quad_decoder u_dec (
    .first_lvl   (first_lvl),
    .first_rise  (first_rise),
    .first_fall  (first_fall),
    .second_lvl  (second_lvl),
    .second_rise (second_rise),
    .second_fall (second_fall),
    .mode        (slave_behaviour_sel_q),
    .result      (enc),
    .any_edge    (enc_edge)
  );

  // Decode
  logic wr_ctl, wr_smc, wr_ier, wr_flag, wr_evt, wr_mode, wr_ep, wr_cnt, wr_wrap;
  logic [NCH-1:0] wr_cmp;
  assign wr_ctl  = wr_en && addr == CONTROL_ONE_OFS;
  assign wr_smc  = wr_en && addr == SLAVE_CONTROL_OFS;
  assign wr_ier  = wr_en && addr == IRQ_DMA_ENABLE_OFS;
  assign wr_flag = wr_en && addr == FLAG_OFS;
  assign wr_evt  = wr_en && addr == EVENT_TRIGGER_OFS;
  assign wr_mode = wr_en && addr == CH_MODE_OFS;
  assign wr_ep   = wr_en && addr == CH_ENABLE_POL_OFS;
  assign wr_cnt  = wr_en && addr == COUNT_OFS;
  assign wr_wrap = wr_en && addr == WRAP_OFS;

  logic encoder_mode, trigger_mode;
  assign encoder_mode = slave_behaviour_sel_q == SM_ENC_SECOND ||
                        slave_behaviour_sel_q == SM_ENC_FIRST ||
                        slave_behaviour_sel_q == SM_ENC_BOTH;
  assign trigger_mode = slave_behaviour_sel_q == SM_TRIGGER;

  // Slave trigger choice; synchronised inputs only map when own pin selected
  logic slave_trigger_in, trig_edge;
  always_comb begin
    slave_trigger_in = 1'b0;
    case (trigger_source_sel_q)
      TS_SECOND: slave_trigger_in = (input_map_select_q[1] == MAP_OWN_PIN) & second_lvl;
      TS_FIRST:  slave_trigger_in = (input_map_select_q[0] == MAP_OWN_PIN) & first_lvl;
      default:   slave_trigger_in = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) trig_lvl_q <= 1'b0;
    else     trig_lvl_q <= slave_trigger_in;
  end
  assign trig_edge = slave_trigger_in & ~trig_lvl_q;

  // Events
  logic force_update, phase_switch_event, update_event, trig_start;
  assign force_update       = wr_evt && wdata[FUPD_POS];
  assign phase_switch_event = (wr_evt && wdata[PHASE_EV_POS]) || trig_edge;
  assign trig_start         = trigger_mode && trig_edge;

  // Rollover detection, both directions
  logic at_top, at_zero, enc_step;
  assign at_top   = cnt_q >= wrap_act_q;
  assign at_zero  = cnt_q == '0;
  assign enc_step = encoder_mode && counter_run_bit_q && enc.step;
  logic cnt_tick;
  assign cnt_tick = encoder_mode ? enc_step : counter_run_bit_q;
  logic tick_down;
  assign tick_down = encoder_mode ? enc.down : dir_q;
  assign update_event = force_update ||
                        (cnt_tick && (tick_down ? at_zero : at_top));

  // Counter; wraps between zero and the limit either way
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (wr_cnt) begin
      cnt_q <= wdata[CNT_W-1:0];
    end else if (force_update) begin
      cnt_q <= tick_down ? wrap_act_q : '0;
    end else if (cnt_tick) begin
      if (tick_down) cnt_q <= at_zero ? wrap_act_q : cnt_q - 16'h0001;
      else           cnt_q <= at_top ? '0 : cnt_q + 16'h0001;
    end
  end

  // Run bit: set by software or trigger, cleared at rollover update in single shot, except in encoder mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      counter_run_bit_q <= 1'b0;
    end else if (trig_start) begin
      counter_run_bit_q <= 1'b1;
    end else if (single_shot_bit_q && update_event && !force_update && !encoder_mode) begin
      counter_run_bit_q <= 1'b0;
    end else if (wr_ctl) begin
      counter_run_bit_q <= wdata[RUN_POS];
    end
  end

  // Other control one bits; direction owned by hardware in encoder mode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      single_shot_bit_q     <= 1'b0;
      dir_q                 <= 1'b0;
      wrap_preload_enable_q <= 1'b0;
    end else begin
      if (wr_ctl) begin
        single_shot_bit_q     <= wdata[SHOT_POS];
        wrap_preload_enable_q <= wdata[WPRE_POS];
      end
      if (encoder_mode && enc_edge) dir_q <= enc.down;
      else if (wr_ctl && !encoder_mode) dir_q <= wdata[DIR_POS];
    end
  end

  // Slave control and enables
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slave_behaviour_sel_q     <= '0;
      trigger_source_sel_q      <= '0;
      cfg_preload_q             <= 1'b0;
      phase_switch_irq_enable_q <= 1'b0;
      phase_switch_dma_enable_q <= 1'b0;
    end else begin
      if (wr_smc) begin
        slave_behaviour_sel_q <= wdata[SMODE_POS +: 3];
        trigger_source_sel_q  <= wdata[TSRC_POS +: 3];
        cfg_preload_q         <= wdata[PRELOAD_CTRL_POS];
      end
      if (wr_ier) begin
        phase_switch_irq_enable_q <= wdata[PHASE_POS];
        phase_switch_dma_enable_q <= wdata[DMA_PHASE_POS];
      end
    end
  end

  // Flag: set wins over software clear-by-zero
  always_ff @(posedge sys_clk) begin
    if (rst) phase_switch_flag_q <= 1'b0;
    else if (phase_switch_event) phase_switch_flag_q <= 1'b1;
    else if (wr_flag && !wdata[PHASE_POS]) phase_switch_flag_q <= 1'b0;
  end
  assign phase_switch_irq     = phase_switch_flag_q & phase_switch_irq_enable_q;
  assign phase_switch_dma_req = phase_switch_event & phase_switch_dma_enable_q;

  // Wrap limit with optional preload
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrap_pre_q <= WRAP_RST;
      wrap_act_q <= WRAP_RST;
    end else begin
      if (wr_wrap) wrap_pre_q <= wdata[CNT_W-1:0];
      if (wr_wrap && !wrap_preload_enable_q) wrap_act_q <= wdata[CNT_W-1:0];
      else if (update_event) wrap_act_q <= wrap_pre_q;
    end
  end

  // Per channel state
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic wr_c;
      logic match, pwm, fast_hit;
      logic forced_q;
      assign wr_c = wr_en && addr == COMPARE0_OFS + 8'(4 * g);
      assign wr_cmp[g] = wr_c;

      // Config preload; shadow moves only on event when preloaded
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          cfg_pre_q[g] <= '0;
          cfg_act_q[g] <= '0;
          input_map_select_q[g]       <= '0;
          fast_output_enable_q[g]     <= 1'b0;
          compare_preload_enable_q[g] <= 1'b0;
          out_polarity_q[g]           <= 1'b0;
        end else begin
          if (wr_mode) begin
            input_map_select_q[g]        <= wdata[g*CH_STRIDE +: 2];
            fast_output_enable_q[g]      <= wdata[g*CH_STRIDE + 2];
            compare_preload_enable_q[g]  <= wdata[g*CH_STRIDE + 3];
            cfg_pre_q[g].output_mode_field <= wdata[g*CH_STRIDE + 4 +: 3];
          end
          if (wr_ep) begin
            cfg_pre_q[g].main_output_enable          <= wdata[g*EP_STRIDE];
            out_polarity_q[g]                        <= wdata[g*EP_STRIDE + 1];
            cfg_pre_q[g].complementary_output_enable <= wdata[g*EP_STRIDE + 2];
          end
          if (!cfg_preload_q) cfg_act_q[g] <= cfg_pre_q[g];
          else if (phase_switch_event) cfg_act_q[g] <= cfg_pre_q[g];
        end
      end

      // Compare value with optional preload
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          cmp_pre_q[g] <= '0;
          cmp_act_q[g] <= '0;
        end else begin
          if (wr_c) cmp_pre_q[g] <= wdata[CNT_W-1:0];
          if (wr_c && !compare_preload_enable_q[g]) cmp_act_q[g] <= wdata[CNT_W-1:0];
          else if (update_event) cmp_act_q[g] <= cmp_pre_q[g];
        end
      end

      // Reference output; compare path runs in every slave mode
      assign pwm   = cfg_act_q[g].output_mode_field == OM_PWM1 ||
                     cfg_act_q[g].output_mode_field == OM_PWM2;
      assign match = cnt_q >= cmp_act_q[g];
      assign fast_hit = fast_output_enable_q[g] && pwm && trig_start;

      // Forced level holds until the update ends the pulse, not one tick
      always_ff @(posedge sys_clk) begin
        if (rst) forced_q <= 1'b0;
        else if (fast_hit) forced_q <= 1'b1;
        else if (update_event) forced_q <= 1'b0;
      end
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          ref_q[g] <= 1'b0;
        end else if (fast_hit) begin
          ref_q[g] <= cfg_act_q[g].output_mode_field == OM_PWM2;
        end else begin
          case (cfg_act_q[g].output_mode_field)
            OM_PWM2: ref_q[g] <= match | forced_q;
            OM_PWM1: ref_q[g] <= ~(match | forced_q);
            default: ref_q[g] <= 1'b0;
          endcase
        end
      end

      assign reference_output[g]     = ref_q[g];
      assign main_output[g]          = cfg_act_q[g].main_output_enable &
                                       (ref_q[g] ^ out_polarity_q[g]);
      assign complementary_output[g] = cfg_act_q[g].complementary_output_enable & ~ref_q[g];
    end
  endgenerate

  // Read mux, data one cycle later
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else if (rd_en) begin
      rdata_q <= '0;
      case (addr)
        CONTROL_ONE_OFS: begin
          rdata_q[RUN_POS]  <= counter_run_bit_q;
          rdata_q[SHOT_POS] <= single_shot_bit_q;
          rdata_q[DIR_POS]  <= dir_q;
          rdata_q[WPRE_POS] <= wrap_preload_enable_q;
        end
        SLAVE_CONTROL_OFS: begin
          rdata_q[SMODE_POS +: 3]   <= slave_behaviour_sel_q;
          rdata_q[TSRC_POS +: 3]    <= trigger_source_sel_q;
          rdata_q[PRELOAD_CTRL_POS] <= cfg_preload_q;
        end
        IRQ_DMA_ENABLE_OFS: begin
          rdata_q[PHASE_POS]     <= phase_switch_irq_enable_q;
          rdata_q[DMA_PHASE_POS] <= phase_switch_dma_enable_q;
        end
        FLAG_OFS:  rdata_q[PHASE_POS] <= phase_switch_flag_q;
        COUNT_OFS: rdata_q[CNT_W-1:0] <= cnt_q;
        WRAP_OFS:  rdata_q[CNT_W-1:0] <= wrap_pre_q;
        default:   rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign rdata       = rdata_q;
  assign count_value = cnt_q;
endmodule // tim_ext_core

// ===== verification/quad_source.sv
`timescale 1ns/1ps
// Encoder stand-in: Gray phase, so only one pin moves per step
module quad_source (
  input  wire logic sys_clk,
  input  wire logic step_fwd,
  input  wire logic step_rev,
  output logic      pin_a,
  output logic      pin_b
);
  logic [1:0] phase_q = 2'h0;

  // Position is mechanical, so the timer reset leaves it alone
  always_ff @(posedge sys_clk) begin
    if (step_fwd) phase_q <= phase_q + 2'h1;
    else if (step_rev) phase_q <= phase_q - 2'h1;
  end

  // Phase to pin levels
  assign pin_a = phase_q[1] ^ phase_q[0];
  assign pin_b = phase_q[1];
endmodule // quad_source

// ===== verification/tim_ext_core_checker.sv
`timescale 1ns/1ps
module tim_ext_core_checker
  import tim_ext_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              first_timer_pin,
  input wire logic              second_timer_pin,
  input wire logic [NCH-1:0]    reference_output,
  input wire logic [NCH-1:0]    main_output,
  input wire logic [NCH-1:0]    complementary_output,
  input wire logic              phase_switch_irq,
  input wire logic              phase_switch_dma_req,
  input wire logic [CNT_W-1:0]  count_value
);
  logic irq_en_q;
  logic dma_en_q;
  logic enc_q;
  logic shot_q;
  logic pre_q;
  logic ev_wr;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Software phase switch request
  assign ev_wr = wr_en && addr == EVENT_TRIGGER_OFS && wdata[PHASE_EV_POS];

  // Mirror of settings; hardware never changes these bits
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_en_q <= 1'b0;
      dma_en_q <= 1'b0;
      enc_q    <= 1'b0;
      shot_q   <= 1'b0;
      pre_q    <= 1'b0;
    end else if (wr_en) begin
      if (addr == IRQ_DMA_ENABLE_OFS) begin
        irq_en_q <= wdata[PHASE_POS];
        dma_en_q <= wdata[DMA_PHASE_POS];
      end
      if (addr == SLAVE_CONTROL_OFS) begin
        enc_q <= wdata[2:0] inside {3'h1, 3'h2, 3'h3};
        pre_q <= wdata[PRELOAD_CTRL_POS];
      end
      if (addr == CONTROL_ONE_OFS) shot_q <= wdata[SHOT_POS];
    end
  end

  a_dma_sw_event: assert property (ev_wr && dma_en_q |-> phase_switch_dma_req)
    else $error("dma request missing on software switch");
  a_dma_gated: assert property (phase_switch_dma_req |-> dma_en_q)
    else $error("dma request while disabled");
  a_irq_gated: assert property (phase_switch_irq |-> irq_en_q)
    else $error("irq while disabled");
  a_irq_follows: assert property (ev_wr && irq_en_q |=> phase_switch_irq)
    else $error("irq missing after switch");
  a_flag_clear: assert property (wr_en && addr == FLAG_OFS && !wdata[PHASE_POS]
    && !phase_switch_dma_req |=> !phase_switch_irq) else $error("flag not cleared");
  a_comp_vs_ref: assert property (pre_q && dma_en_q && !phase_switch_dma_req
    && !(wr_en && addr == CH_ENABLE_POL_OFS) ##1 $stable(reference_output)
    |-> $stable(main_output | complementary_output)) else $error("outputs moved without switch");
  a_count_steps: assert property (!$past(wr_en) && !$past(wr_en, 2) && $changed(count_value)
    |-> count_value == $past(count_value) + 16'h1 || count_value == $past(count_value) - 16'h1
    || count_value == 16'h0 || $past(count_value) == 16'h0) else $error("count jumped");
  a_single_stop: assert property (shot_q && !enc_q && !$past(wr_en) && !$past(wr_en, 2)
    && $past(count_value) != 16'h0 && count_value == 16'h0 |=> (count_value == 16'h0) [*3])
    else $error("single shot kept running");
  a_reset_quiet: assert property ($fell(rst) |-> main_output == '0 && complementary_output == '0)
    else $error("outputs active after reset");
endmodule // tim_ext_core_checker

bind tim_ext_core tim_ext_core_checker u_tim_ext_core_checker (
  .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
  .rdata(rdata), .first_timer_pin(first_timer_pin), .second_timer_pin(second_timer_pin),
  .reference_output(reference_output), .main_output(main_output),
  .complementary_output(complementary_output), .phase_switch_irq(phase_switch_irq),
  .phase_switch_dma_req(phase_switch_dma_req), .count_value(count_value)
);

// ===== verification/test_tim_ext_core.sv
`timescale 1ns/1ps
module test_tim_ext_core
  import tim_ext_pkg::*;
;
  localparam logic [CNT_W-1:0] PW = 16'h0014;
  localparam logic [CNT_W-1:0] PC = 16'h0006;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic              step_fwd = 1'b0;
  logic              step_rev = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              pin_a;
  logic              pin_b;
  logic [NCH-1:0]    ref_out;
  logic [NCH-1:0]    main_out;
  logic [NCH-1:0]    comp_out;
  logic              irq;
  logic              dma;
  logic [CNT_W-1:0]  count;
  int                n_errors = 0;
  int                check_count = 0;

  // 100 MHz
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  tim_ext_core u_tim_ext_core (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .first_timer_pin(pin_a), .second_timer_pin(pin_b),
    .reference_output(ref_out), .main_output(main_out), .complementary_output(comp_out),
    .phase_switch_irq(irq), .phase_switch_dma_req(dma), .count_value(count)
  );
  quad_source u_quad_source (
    .sys_clk(sys_clk), .step_fwd(step_fwd), .step_rev(step_rev), .pin_a(pin_a), .pin_b(pin_b)
  );

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Every write also confirms whether a dma pulse rides with it
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                    input logic exp_dma = 1'b0);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    #1 check(dma, exp_dma);
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  // Read data only stands in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // Six idle cycles cover the input synchroniser
  task automatic step(input logic fwd);
    @(posedge sys_clk);
    step_fwd <= fwd;
    step_rev <= !fwd;
    @(posedge sys_clk);
    step_fwd <= 1'b0;
    step_rev <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  task automatic rise_second();
    for (int i = 0; i < 4 && pin_b !== 1'b0; i++) step(1'b1);
    for (int i = 0; i < 4 && pin_b !== 1'b1; i++) step(1'b1);
  endtask

  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // Two channels staged, then switched by software and by trigger edge
  task automatic phase_switch_test();
    wr(SLAVE_CONTROL_OFS, 32'h00000100);
    wr(IRQ_DMA_ENABLE_OFS, 32'h00002020);
    wr(CH_ENABLE_POL_OFS, 32'h00000055);
    wr(CH_MODE_OFS, 32'h00007170);
    settle();
    check(main_out | comp_out, 4'h0);
    wr(EVENT_TRIGGER_OFS, 32'h00000020, 1'b1);
    settle();
    check(main_out ^ comp_out, 4'h3);
    check(irq, 1'b1);
    rd(FLAG_OFS, 32'h00000020);
    wr(FLAG_OFS, 32'h0);
    wr(CH_ENABLE_POL_OFS, 32'h0);
    settle();
    check(irq, 1'b0);
    check(main_out ^ comp_out, 4'h3);
    wr(SLAVE_CONTROL_OFS, 32'h00000160);
    rise_second();
    check(main_out | comp_out, 4'h0);
    check(irq, 1'b1);
  endtask

  // Pulse timing measured against the counter itself
  task automatic pulse_test(input logic fast);
    int ts;
    int tc;
    int tr;
    int tf;
    int t0;
    ts = -1;
    tc = -1;
    tr = -1;
    tf = -1;
    t0 = -1;
    do_reset();
    // Trigger pin low first, else selecting it reads as an edge
    for (int i = 0; i < 4 && pin_b !== 1'b0; i++) step(1'b1);
    wr(WRAP_OFS, {16'h0, PW});
    wr(COMPARE0_OFS, {16'h0, PC});
    wr(CH_MODE_OFS, {16'h0, 8'h01, 1'b0, 3'h7, 1'b1, fast, 2'h0});
    wr(CONTROL_ONE_OFS, 32'h00000088);
    wr(SLAVE_CONTROL_OFS, 32'h00000066);
    wr(EVENT_TRIGGER_OFS, 32'h00000001);
    settle();
    check(count, 16'h0);
    fork
      rise_second();
      for (int i = 0; i < 120; i++) begin
        @(posedge sys_clk);
        #1;
        if (count == 16'h0001 && ts < 0) ts = i - 1;
        if (count == PC && tc < 0) tc = i;
        if (ref_out[0] === 1'b1 && tr < 0) tr = i;
        if (tr >= 0 && ref_out[0] === 1'b0 && tf < 0) tf = i;
        if (tc >= 0 && count == 16'h0 && t0 < 0) t0 = i;
      end
    join
    if (ts < 0 || tr < 0 || tf < 0 || t0 < 0) begin
      n_errors++;
      finish_test();
    end
    check(tc - ts, PC);
    check(t0 - tc - 1, PW - PC);
    check((tf - t0) inside {0, 1}, 1'b1);
    if (fast) check(tr < tc, 1'b1);
    else check((tr - tc) inside {0, 1}, 1'b1);
    check(count, 16'h0);
    rd(CONTROL_ONE_OFS, 32'h00000088);
  endtask

  // First step with the counter stopped moves direction only
  task automatic enc_test(input logic [2:0] mode, input logic [1:0] pol);
    logic             a;
    logic             b;
    logic             dir;
    logic             run;
    logic             en;
    logic [CNT_W-1:0] exp_cnt;
    do_reset();
    wr(WRAP_OFS, 32'h00000005);
    wr(CH_ENABLE_POL_OFS, {26'h0, pol[1], 3'h0, pol[0], 1'b0});
    repeat (8) @(posedge sys_clk);
    wr(SLAVE_CONTROL_OFS, {29'h0, mode});
    exp_cnt = 16'h0;
    dir = 1'b0;
    run = 1'b0;
    for (int i = 0; i < 14; i++) begin
      if (i == 1) begin
        wr(CONTROL_ONE_OFS, 32'h00000001);
        run = 1'b1;
      end
      a = pin_a ^ pol[0];
      b = pin_b ^ pol[1];
      step(i < 8);
      if ((pin_a ^ pol[0]) != a) begin
        dir = !(pin_a ^ pol[0] ^ b);
        en = mode[1] & run;
      end else begin
        dir = pin_b ^ pol[1] ^ a;
        en = mode[0] & run;
      end
      if (en && dir) exp_cnt = (exp_cnt == 16'h0) ? 16'h0005 : exp_cnt - 16'h1;
      else if (en) exp_cnt = (exp_cnt == 16'h0005) ? 16'h0 : exp_cnt + 16'h1;
      check(count, exp_cnt);
      rd(CONTROL_ONE_OFS, {27'h0, dir, 3'h0, run});
    end
  endtask

  // Main sequence
  initial begin
    do_reset();
    rd(WRAP_OFS, 32'h0000FFFF);
    rd(CH_MODE_OFS, 32'h0);
    rd(CH_ENABLE_POL_OFS, 32'h0);
    rd(8'hFC, 32'h0);
    phase_switch_test();
    pulse_test(1'b0);
    pulse_test(1'b1);
    enc_test(SM_ENC_SECOND, 2'h0);
    enc_test(SM_ENC_FIRST, 2'h0);
    enc_test(SM_ENC_BOTH, 2'h0);
    enc_test(SM_ENC_BOTH, 2'h1);
    finish_test();
  end
endmodule // test_tim_ext_core
